//--- rtl/misc_settings_pkg.sv
package misc_settings_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] MISC_SETTINGS_ADDR = 12'h000;
  localparam int          ADDR_W             = 12;

  // ==========================================================
  // Field positions
  localparam int REF_SEL_BIT     = 25;
  localparam int BOOT_LATCH_BIT  = 24;
  localparam int SLOW_RATE_LSB   = 19;
  localparam int SLOW_DELAY_LSB  = 16;
  localparam int OUT_STARTUP_LSB = 14;
  localparam int SSC_SYNC_BIT    = 7;
  localparam int XTAL_PRI_BIT    = 6;
  localparam int XTAL_MODE_LSB   = 3;

  // Writable bits; reserved and out-of-block bits read zero
  localparam logic [31:0] WRITE_MASK = 32'h03FF_C0D8;

  // ==========================================================
  // Reset values, rate limit and field codes
  localparam logic [4:0] SLOW_RATE_RST  = 5'h10;
  localparam logic [4:0] SLOW_RATE_MAX  = 5'h14;
  localparam logic [2:0] SLOW_DELAY_RST = 3'h5;
  localparam logic [1:0] OUT_GATED      = 2'h0;
  localparam logic [1:0] OUT_UNGATED    = 2'h2;
  localparam logic [3:0] GPIO_XTAL_FUNC = 4'h6;

  typedef enum logic [1:0] {
    XTAL_FORCE_PRIMARY = 2'h0,
    XTAL_FORCE_BACKUP  = 2'h1,
    XTAL_AUTO          = 2'h2
  } xtal_mode_t;

  // ==========================================================
  // Timing
  localparam int CLOCK_MHZ     = 200;
  localparam int SLOW_TICK_US  = 1;
  localparam int CYCLES_PER_US = CLOCK_MHZ * SLOW_TICK_US;
  localparam int US_PER_MS     = 1000;

  // Start delay codes in milliseconds
  localparam logic [16:0] DELAY_MS_1 = 17'h00001;
  localparam logic [16:0] DELAY_MS_2 = 17'h0000A;
  localparam logic [16:0] DELAY_MS_3 = 17'h00064;
  localparam logic [16:0] DELAY_MS_4 = 17'h003E8;
  localparam logic [16:0] DELAY_MS_5 = 17'h02710;
  localparam logic [16:0] DELAY_MS_6 = 17'h186A0;

  typedef struct packed {
    logic       refOriginal;
    logic       bootLatch;
    logic [4:0] slowRate;
    logic [2:0] slowDelay;
    logic [1:0] outStartup;
    logic       sscSync;
    logic       xtalPri;
    logic [1:0] xtalMode;
  } cfg_t;

  typedef struct packed {
    logic [1:0] xtalLos;
    logic [1:0] xtalStFail;
    logic       gpioLevel;
    logic       loopLocked;
  } pins_t;

endpackage

//--- rtl/slow_start_timer.sv
`timescale 1ns/1ps
`default_nettype none
module slow_start_timer #(
  parameter int US_PER_MS = misc_settings_pkg::US_PER_MS
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       usTick,
  input  wire logic       slowEnable,
  input  wire logic       accelDone,
  input  wire logic [2:0] delayCode,
  output logic            slowActive
);

  logic [16:0] targetMs_q;
  logic [16:0] msCnt_q;
  logic [31:0] usCnt_q;
  logic        waiting_q;

  function automatic logic [16:0] delayMs(input logic [2:0] code);
    unique case (code)
      3'h0:    delayMs = 17'h00000;
      3'h1:    delayMs = misc_settings_pkg::DELAY_MS_1;
      3'h2:    delayMs = misc_settings_pkg::DELAY_MS_2;
      3'h3:    delayMs = misc_settings_pkg::DELAY_MS_3;
      3'h4:    delayMs = misc_settings_pkg::DELAY_MS_4;
      3'h5:    delayMs = misc_settings_pkg::DELAY_MS_5;
      default: delayMs = misc_settings_pkg::DELAY_MS_6;
    endcase
  endfunction

  // ==========================================================
  // Delay count, restarted by each end of accelerated calibration
  always_ff @(posedge clock) begin
    if (!rst_n || !slowEnable) begin
      waiting_q  <= 1'b0;
      slowActive <= 1'b0;
      msCnt_q    <= 17'h00000;
      usCnt_q    <= 32'h0000_0000;
      targetMs_q <= 17'h00000;
    end else if (accelDone) begin
      waiting_q  <= 1'b1;
      slowActive <= 1'b0;
      msCnt_q    <= 17'h00000;
      usCnt_q    <= 32'h0000_0000;
      targetMs_q <= delayMs(delayCode);
    end else if (waiting_q) begin
      if (msCnt_q == targetMs_q) begin
        waiting_q  <= 1'b0;
        slowActive <= 1'b1;
      end else if (usTick) begin
        if (usCnt_q == 32'(US_PER_MS - 1)) begin
          usCnt_q <= 32'h0000_0000;
          msCnt_q <= msCnt_q + 17'h00001;
        end else begin
          usCnt_q <= usCnt_q + 32'h0000_0001;
        end
      end
    end
  end

  property p_zero_delay;
    @(posedge clock) disable iff (!rst_n)
      (accelDone && slowEnable && delayCode == 3'h0) |=> ##1 slowActive;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

  property p_not_early;
    @(posedge clock) disable iff (!rst_n)
      (accelDone && slowEnable && delayCode != 3'h0) |=> !slowActive [*2];
  endproperty
  a_not_early: assert property (p_not_early) else $error("slow filter started early");

endmodule
`default_nettype wire

//--- rtl/misc_settings.sv
// Behaviour
// - Bit 25 at 0 sends the resampled reference to calibration and monitoring, at 1 the original.
// - Bit 24 at 0 allows event latching only after boot ends, at 1 during boot as well.
// - Slow-filter updates run at 1 MHz over two to the field value, 0 to 20, default 16.
// - After accelerated calibration the slow filter starts after the coded delay, default 10 s.
// - Startup code 0 holds outputs and monitors off until loop lock, code 2 ignores lock.
// - Bit 7 aligns spread engine 1 to engine 0 when their rates match, else it runs free.
// - With both crystals valid under automatic choice, bit 6 picks crystal 0 or crystal 1 while startup runs.
// - Mode 0 forces primary, 1 forces backup, 2 picks from monitors and a function-6 pin while startup runs, then holds.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module misc_settings #(
  parameter int CYCLES_PER_US = misc_settings_pkg::CYCLES_PER_US,
  parameter int US_PER_MS     = misc_settings_pkg::US_PER_MS
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire misc_settings_pkg::pins_t  pinsAsync,
  input  wire logic [3:0]                gpioFunc,
  input  wire logic                      bootDone,
  input  wire logic                      startupDone,
  input  wire logic                      sscSameRate,
  input  wire logic                      slowEnable,
  input  wire logic                      accelDone,
  output logic                           refUseOriginal,
  output logic                           eventLatchEnable,
  output logic                           slowUpdateTick,
  output logic                           slowFilterActive,
  output logic                           outputsEnable,
  output logic                           sscAlign,
  output logic                           xtalSelect
);

  misc_settings_pkg::cfg_t  cfg;
  misc_settings_pkg::pins_t pinsMeta_q;
  misc_settings_pkg::pins_t pins_q;
  logic [31:0] reg_q;
  logic [31:0] regRead;
  logic [31:0] byteMask;
  logic        hit;
  logic        wrEn;
  logic [31:0] usCnt_q;
  logic        usTick;
  logic [19:0] rateCnt_q;
  logic [19:0] rateMask;
  logic [4:0]  rateUsed;
  logic        lockSeen_q;
  logic [1:0]  xtalValid;
  logic        bothValid;

  // ==========================================================
  // APB slave, zero wait states
  assign hit     = (paddr == misc_settings_pkg::MISC_SETTINGS_ADDR);
  assign wrEn    = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign byteMask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_q <= {6'h00, 1'b0, 1'b0, misc_settings_pkg::SLOW_RATE_RST,
                misc_settings_pkg::SLOW_DELAY_RST, misc_settings_pkg::OUT_GATED,
                6'h00, 1'b0, 1'b0, 1'b0, 2'(misc_settings_pkg::XTAL_AUTO), 3'h0};
    end else if (wrEn) begin
      // Masking keeps the reserved bits at zero
      reg_q <= (reg_q & ~(byteMask & misc_settings_pkg::WRITE_MASK))
             | (pwdata & byteMask & misc_settings_pkg::WRITE_MASK);
    end
  end

  assign regRead = reg_q & misc_settings_pkg::WRITE_MASK;

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= hit ? regRead : 32'h0000_0000;
    end
  end

  assign cfg.refOriginal = reg_q[misc_settings_pkg::REF_SEL_BIT];
  assign cfg.bootLatch   = reg_q[misc_settings_pkg::BOOT_LATCH_BIT];
  assign cfg.slowRate    = reg_q[misc_settings_pkg::SLOW_RATE_LSB +: 5];
  assign cfg.slowDelay   = reg_q[misc_settings_pkg::SLOW_DELAY_LSB +: 3];
  assign cfg.outStartup  = reg_q[misc_settings_pkg::OUT_STARTUP_LSB +: 2];
  assign cfg.sscSync     = reg_q[misc_settings_pkg::SSC_SYNC_BIT];
  assign cfg.xtalPri     = reg_q[misc_settings_pkg::XTAL_PRI_BIT];
  assign cfg.xtalMode    = reg_q[misc_settings_pkg::XTAL_MODE_LSB +: 2];

  // ==========================================================
  // Pin synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pinsMeta_q <= '0;
      pins_q     <= '0;
    end else begin
      pinsMeta_q <= pinsAsync;
      pins_q     <= pinsMeta_q;
    end
  end

  // ==========================================================
  // Reference choice, event latching, spread alignment
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refUseOriginal   <= 1'b0;
      eventLatchEnable <= 1'b0;
      sscAlign         <= 1'b0;
    end else begin
      refUseOriginal   <= cfg.refOriginal;
      eventLatchEnable <= bootDone || cfg.bootLatch;
      sscAlign         <= cfg.sscSync && sscSameRate;
    end
  end

  // ==========================================================
  // Slow-filter update tick
  always_ff @(posedge clock) begin
    if (!rst_n || usTick) begin
      usCnt_q <= 32'h0000_0000;
    end else begin
      usCnt_q <= usCnt_q + 32'h0000_0001;
    end
  end

  assign usTick = (usCnt_q == 32'(CYCLES_PER_US - 1));
  // Out-of-range codes run at the slowest legal rate
  assign rateUsed = (cfg.slowRate > misc_settings_pkg::SLOW_RATE_MAX) ?
                    misc_settings_pkg::SLOW_RATE_MAX : cfg.slowRate;
  assign rateMask = 20'((21'h000001 << rateUsed) - 21'h000001);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rateCnt_q      <= 20'h00000;
      slowUpdateTick <= 1'b0;
    end else begin
      slowUpdateTick <= usTick && ((rateCnt_q & rateMask) == rateMask);
      if (usTick) begin
        rateCnt_q <= rateCnt_q + 20'h00001;
      end
    end
  end

  slow_start_timer #(
    .US_PER_MS (US_PER_MS)
  ) u_start (
    .clock      (clock),
    .rst_n      (rst_n),
    .usTick     (usTick),
    .slowEnable (slowEnable),
    .accelDone  (accelDone),
    .delayCode  (cfg.slowDelay),
    .slowActive (slowFilterActive)
  );

  // ==========================================================
  // Output gating on loop lock; lock once seen keeps outputs up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lockSeen_q    <= 1'b0;
      outputsEnable <= 1'b0;
    end else begin
      if (pins_q.loopLocked) begin
        lockSeen_q <= 1'b1;
      end
      outputsEnable <= (cfg.outStartup == misc_settings_pkg::OUT_UNGATED)
                    || lockSeen_q || pins_q.loopLocked;
    end
  end

  // ==========================================================
  // Crystal choice; forced modes apply at any time, automatic choice only while startup runs
  always_comb begin
    xtalValid = ~(pins_q.xtalLos | pins_q.xtalStFail);
    if (gpioFunc == misc_settings_pkg::GPIO_XTAL_FUNC && pins_q.gpioLevel) begin
      xtalValid[0] = 1'b0;
    end
  end

  assign bothValid = &xtalValid;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      xtalSelect <= 1'b0;
    end else begin
      unique case (cfg.xtalMode)
        2'(misc_settings_pkg::XTAL_FORCE_PRIMARY): xtalSelect <= 1'b0;
        2'(misc_settings_pkg::XTAL_FORCE_BACKUP):  xtalSelect <= 1'b1;
        default: begin
          // Automatic choice holds once startup ends
          if (!startupDone) begin
            if (bothValid) begin
              xtalSelect <= cfg.xtalPri;
            end else if (xtalValid != 2'b00) begin
              xtalSelect <= xtalValid[1];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  sequence s_write_ref1;
    wrEn && pstrb[3] && pwdata[misc_settings_pkg::REF_SEL_BIT];
  endsequence

  sequence s_ref_follows;
    ##2 refUseOriginal;
  endsequence

  property p_ref_sel;
    @(posedge clock) disable iff (!rst_n) s_write_ref1 |-> s_ref_follows;
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select not applied");

  property p_boot_latch;
    @(posedge clock) disable iff (!rst_n)
      (!bootDone && !cfg.bootLatch) |=> !eventLatchEnable;
  endproperty
  a_boot_latch: assert property (p_boot_latch) else $error("event latch during boot");

  property p_reserved;
    @(posedge clock) disable iff (!rst_n) (reg_q & ~misc_settings_pkg::WRITE_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_rate0;
    @(posedge clock) disable iff (!rst_n)
      (usTick && cfg.slowRate == 5'h00) |=> slowUpdateTick;
  endproperty
  a_rate0: assert property (p_rate0) else $error("rate 0 tick missing");

  property p_gated;
    @(posedge clock) disable iff (!rst_n)
      (cfg.outStartup == misc_settings_pkg::OUT_GATED && !lockSeen_q && !pins_q.loopLocked)
        |=> !outputsEnable;
  endproperty
  a_gated: assert property (p_gated) else $error("outputs up before lock");

  property p_ssc;
    @(posedge clock) disable iff (!rst_n) !cfg.sscSync |=> !sscAlign;
  endproperty
  a_ssc: assert property (p_ssc) else $error("engine 1 aligned while free");

  property p_prio;
    @(posedge clock) disable iff (!rst_n)
      (cfg.xtalMode == 2'h2 && !startupDone && bothValid) |=> xtalSelect == $past(cfg.xtalPri);
  endproperty
  a_prio: assert property (p_prio) else $error("crystal priority ignored");

  property p_force;
    @(posedge clock) disable iff (!rst_n) (cfg.xtalMode == 2'h1) |=> xtalSelect;
  endproperty
  a_force: assert property (p_force) else $error("backup not forced");

  property p_primary;
    @(posedge clock) disable iff (!rst_n) (cfg.xtalMode == 2'h0) |=> !xtalSelect;
  endproperty
  a_primary: assert property (p_primary) else $error("primary not forced");

  // Mode 3 decodes as automatic, so only the upper mode bit matters
  property p_xtal_hold;
    @(posedge clock) disable iff (!rst_n)
      (cfg.xtalMode[1] && startupDone) |=> $stable(xtalSelect);
  endproperty
  a_xtal_hold: assert property (p_xtal_hold) else $error("crystal changed after startup");

  property p_ref_level;
    @(posedge clock) disable iff (!rst_n) 1'b1 |=> refUseOriginal == $past(cfg.refOriginal);
  endproperty
  a_ref_level: assert property (p_ref_level) else $error("reference choice stale");

  property p_boot_open;
    @(posedge clock) disable iff (!rst_n)
      (bootDone || cfg.bootLatch) |=> eventLatchEnable;
  endproperty
  a_boot_open: assert property (p_boot_open) else $error("event latch blocked");

  property p_ssc_on;
    @(posedge clock) disable iff (!rst_n)
      (cfg.sscSync && sscSameRate) |=> sscAlign;
  endproperty
  a_ssc_on: assert property (p_ssc_on) else $error("engine 1 not aligned");

  property p_ungated;
    @(posedge clock) disable iff (!rst_n)
      (cfg.outStartup == misc_settings_pkg::OUT_UNGATED) |=> outputsEnable;
  endproperty
  a_ungated: assert property (p_ungated) else $error("outputs held while ungated");

  property p_tick_on_us;
    @(posedge clock) disable iff (!rst_n) slowUpdateTick |-> $past(usTick);
  endproperty
  a_tick_on_us: assert property (p_tick_on_us) else $error("update tick off the grid");

endmodule
`default_nettype wire

//--- dv/misc_settings_tb.sv
`timescale 1ns/1ps
`default_nettype none
module misc_settings_tb;
  // ==========================================================
  // Shortened timers keep delay codes 0 to 2 under a hundred cycles
  localparam int CYC_US = 4;
  localparam int MS_US  = 2;

  logic                       clock;
  logic                       rst_n;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [3:0]                 pstrb;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  misc_settings_pkg::pins_t   pins;
  logic [3:0]                 gpioFunc;
  logic                       bootDone;
  logic                       startupDone;
  logic                       sscSameRate;
  logic                       slowEnable;
  logic                       accelDone;
  logic                       refUseOriginal;
  logic                       eventLatchEnable;
  logic                       slowUpdateTick;
  logic                       slowFilterActive;
  logic                       outputsEnable;
  logic                       sscAlign;
  logic                       xtalSelect;
  logic [31:0]                rdata;
  logic                       err;
  int                         num_errors;
  int                         checks;
  int                         n;

  misc_settings #(.CYCLES_PER_US(CYC_US), .US_PER_MS(MS_US)) u_misc_settings (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinsAsync(pins), .gpioFunc(gpioFunc), .bootDone(bootDone),
    .startupDone(startupDone), .sscSameRate(sscSameRate), .slowEnable(slowEnable),
    .accelDone(accelDone), .refUseOriginal(refUseOriginal),
    .eventLatchEnable(eventLatchEnable), .slowUpdateTick(slowUpdateTick),
    .slowFilterActive(slowFilterActive), .outputsEnable(outputsEnable),
    .sscAlign(sscAlign), .xtalSelect(xtalSelect));

  // ==========================================================
  // Helpers
  task check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Starts on its own edge so a release and a new setup never share a time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [31:0] d);
    apb(1'b1, 12'h000, d);
  endtask

  task look(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask

  function automatic logic [31:0] word(input logic refO, input logic boot, input logic [4:0] rate,
      input logic [2:0] dly, input logic [1:0] st, input logic ssc, input logic pri,
      input logic [1:0] mode);
    return {6'h00, refO, boot, rate, dly, st, 6'h00, ssc, pri, 1'b0, mode, 3'h0};
  endfunction

  // Counts falling edges until the chosen output is high, bounded
  task waitFor(input logic act, output int k);
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while ((act ? slowFilterActive : slowUpdateTick) !== 1'b1 && k < 1000);
  endtask

  task doReset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("reset value", rdata, 32'h0085_0010);
    @(negedge clock);
    check("reset outputs", {refUseOriginal, eventLatchEnable, sscAlign, outputsEnable}, 0);
  endtask

  task t_reserved;
    wr(32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("reserved bits", rdata & 32'hFC00_3F27, 32'h0000_0000);
    check("mapped error", err, 0);
    wr(word(1'b1, 1'b0, 5'h03, 3'h2, 2'h2, 1'b1, 1'b1, 2'h1));
    apb(1'b1, 12'h004, 32'h0000_0000);
    check("unmapped write error", err, 1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("unmapped read data", rdata, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("readback", rdata, word(1'b1, 1'b0, 5'h03, 3'h2, 2'h2, 1'b1, 1'b1, 2'h1));
  endtask

  task t_levels;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      bootDone    <= (i == 2);
      sscSameRate <= i[1];
      wr(word(i[0], (i == 1), 5'h00, 3'h0, 2'h0, i[0], 1'b0, 2'h2));
      look(2);
      check("reference select", refUseOriginal, i[0]);
      check("event latch", eventLatchEnable, (i == 1) || (i == 2));
      check("spread align", sscAlign, i[0] & i[1]);
    end
    @(posedge clock);
    bootDone <= 1'b0;
  endtask

  task t_startup;
    wr(word(1'b0, 1'b0, 5'h00, 3'h0, 2'h0, 1'b0, 1'b0, 2'h2));
    look(5);
    check("gated before lock", outputsEnable, 0);
    @(posedge clock);
    pins.loopLocked <= 1'b1;
    look(5);
    check("enabled after lock", outputsEnable, 1);
    @(posedge clock);
    pins.loopLocked <= 1'b0;
    doReset();
    wr(word(1'b0, 1'b0, 5'h00, 3'h0, 2'h2, 1'b0, 1'b0, 2'h2));
    look(5);
    check("ungated", outputsEnable, 1);
  endtask

  // Columns: mode, priority, crystal loss, short-term fail, pin function 6, pin level, choice
  // Expected choices alternate so a stuck output cannot pass
  task t_xtal;
    logic [9:0] tbl [8];
    tbl = '{{2'h1, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1}, {2'h0, 1'b0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b0},
      {2'h2, 1'b0, 2'h1, 2'h0, 1'b0, 1'b0, 1'b1}, {2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0},
      {2'h2, 1'b1, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1}, {2'h2, 1'b1, 2'h0, 2'h2, 1'b0, 1'b0, 1'b0},
      {2'h2, 1'b0, 2'h0, 2'h0, 1'b1, 1'b1, 1'b1}, {2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b0}};
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      pins.xtalLos    <= tbl[i][6:5];
      pins.xtalStFail <= tbl[i][4:3];
      gpioFunc        <= tbl[i][2] ? misc_settings_pkg::GPIO_XTAL_FUNC : 4'h0;
      pins.gpioLevel  <= tbl[i][1];
      wr(word(1'b0, 1'b0, 5'h00, 3'h0, 2'h2, 1'b0, tbl[i][7], tbl[i][9:8]));
      look(5);
      check("crystal choice", xtalSelect, tbl[i][0]);
    end
    // Choice freezes once startup is over, even with crystal 0 lost
    @(posedge clock);
    startupDone  <= 1'b1;
    pins.xtalLos <= 2'h1;
    look(5);
    check("choice held after startup", xtalSelect, 0);
    @(posedge clock);
    startupDone <= 1'b0;
    look(5);
    check("choice with one crystal", xtalSelect, 1);
    @(posedge clock);
    pins     <= '0;
    gpioFunc <= 4'h0;
  endtask

  task t_tick;
    for (int r = 0; r < 4; r += 3) begin
      wr(word(1'b0, 1'b0, r[4:0], 3'h0, 2'h2, 1'b0, 1'b0, 2'h2));
      // First pulses may still follow the old rate
      repeat (2) waitFor(1'b0, n);
      waitFor(1'b0, n);
      check("tick period", n, CYC_US << r);
    end
  endtask

  // Codes 0, 1 and 2: no delay, 1 ms and 10 ms on the shortened timers
  task t_delay;
    int   ms;
    logic ok;
    for (int c = 0; c < 3; c++) begin
      ms = (c == 2) ? 10 : c;
      wr(word(1'b0, 1'b0, 5'h00, c[2:0], 2'h2, 1'b0, 1'b0, 2'h2));
      @(posedge clock);
      slowEnable <= 1'b1;
      accelDone  <= 1'b1;
      @(posedge clock);
      accelDone  <= 1'b0;
      waitFor(1'b1, n);
      // Up to one microsecond of slack from the free-running tick phase
      ok = (n > (ms * MS_US - 1) * CYC_US) && (n <= ms * MS_US * CYC_US + 2);
      check("start delay", ok, 1);
      @(posedge clock);
      slowEnable <= 1'b0;
      look(2);
      check("slow filter off", slowFilterActive, 0);
    end
  endtask

  // ==========================================================
  // Clock, watchdog, main sequence
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #250000;
    num_errors++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pins, gpioFunc, bootDone, startupDone, sscSameRate, slowEnable, accelDone} = '0;
    pstrb      = 4'hF;
    rst_n      = 1'b0;
    num_errors = 0;
    checks     = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_startup();
    t_reserved();
    t_levels();
    t_xtal();
    t_tick();
    t_delay();
    end_sim();
  end
endmodule
`default_nettype wire
